// File: ssp_arbiter.sv
`timescale 1ns/1ps
module ssp_arbiter (
    // Ranks and pending requests
    input wire ssp_pkg::ssp_ranks_t ranks,
    input wire logic [3:0] pending,
    // Winner
    output logic grant_valid,
    output logic [1:0] grant_id
);

    logic [1:0] rank_of [4];
    logic [1:0] best;

    always_comb begin
        rank_of[0] = ranks.seq0_rank;
        rank_of[1] = ranks.seq1_rank;
        rank_of[2] = ranks.seq2_rank;
        rank_of[3] = ranks.seq3_rank;
        grant_valid = 1'b0;
        grant_id = 2'h0;
        best = ssp_pkg::RANK_LEAST;
        // Lowest code wins; ties go to lower index
        for (int i = 0; i < ssp_pkg::NUM_SEQ; i++) begin
            if (pending[i] && (!grant_valid || rank_of[i] < best)) begin
                grant_valid = 1'b1;
                grant_id = 2'(i);
                best = rank_of[i];
            end
        end
    end

endmodule : ssp_arbiter

// File: ssp_pkg.sv
package ssp_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] SEQUENCER_PRIORITY_OFFS = 12'h020;
    localparam logic [11:0] PENDING_STATUS_OFFS = 12'h028;
    localparam logic [31:0] RSVD_READ_VALUE = 32'h0000_0000;

    // ****************************************
    // Field layout and reset values
    // ****************************************
    localparam int NUM_SEQ = 4;
    localparam int RANK_W = 2;
    localparam int SEQ0_LSB = 0;
    localparam int SEQ1_LSB = 4;
    localparam int SEQ2_LSB = 8;
    localparam int SEQ3_LSB = 12;
    localparam logic [1:0] SEQ0_RANK_RST = 2'h0;
    localparam logic [1:0] SEQ1_RANK_RST = 2'h1;
    localparam logic [1:0] SEQ2_RANK_RST = 2'h2;
    localparam logic [1:0] SEQ3_RANK_RST = 2'h3;
    localparam logic [1:0] RANK_LEAST = 2'h3;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [1:0] seq3_rank;
        logic [1:0] seq2_rank;
        logic [1:0] seq1_rank;
        logic [1:0] seq0_rank;
    } ssp_ranks_t;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } ssp_apb_req_t;

    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_RUN = 2'b01
    } ssp_state_t;

endpackage : ssp_pkg

// File: ssp_sequencer_priority.sv
`timescale 1ns/1ps
module ssp_sequencer_priority (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer triggers and conversion engine
    input wire logic [3:0] trigger,
    input wire logic seq_done,
    output logic seq_start,
    output logic [1:0] seq_id,
    output logic seq_busy
);

    // ****************************************
    // Register file
    // ****************************************
    ssp_pkg::ssp_ranks_t ranks_q, ranks_d;
    logic [31:0] prdata_q, prdata_d;
    logic wr_en, rd_en, rd_setup, hit_pri, hit_pend;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    // Read data loaded in setup so it stands at the access edge
    assign rd_setup = psel && !penable && !pwrite;
    assign hit_pri = paddr == ssp_pkg::SEQUENCER_PRIORITY_OFFS;
    assign hit_pend = paddr == ssp_pkg::PENDING_STATUS_OFFS;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_pri && !hit_pend;
    assign prdata = prdata_q;

    function automatic logic [31:0] pack_ranks(ssp_pkg::ssp_ranks_t r);
        logic [31:0] w;
        w = ssp_pkg::RSVD_READ_VALUE;
        w[ssp_pkg::SEQ0_LSB +: ssp_pkg::RANK_W] = r.seq0_rank;
        w[ssp_pkg::SEQ1_LSB +: ssp_pkg::RANK_W] = r.seq1_rank;
        w[ssp_pkg::SEQ2_LSB +: ssp_pkg::RANK_W] = r.seq2_rank;
        w[ssp_pkg::SEQ3_LSB +: ssp_pkg::RANK_W] = r.seq3_rank;
        return w;
    endfunction : pack_ranks

    logic [3:0] pend_q, pend_d;

    always_comb begin
        ranks_d = ranks_q;
        prdata_d = prdata_q;
        if (wr_en && hit_pri) begin
            // Reserved bits of pwdata are dropped
            ranks_d.seq0_rank =
                pwdata[ssp_pkg::SEQ0_LSB +: ssp_pkg::RANK_W];
            ranks_d.seq1_rank =
                pwdata[ssp_pkg::SEQ1_LSB +: ssp_pkg::RANK_W];
            ranks_d.seq2_rank =
                pwdata[ssp_pkg::SEQ2_LSB +: ssp_pkg::RANK_W];
            ranks_d.seq3_rank =
                pwdata[ssp_pkg::SEQ3_LSB +: ssp_pkg::RANK_W];
        end
        if (rd_setup) begin
            if (hit_pri) begin
                prdata_d = pack_ranks(ranks_q);
            end else if (hit_pend) begin
                prdata_d = {28'h0000000, pend_q};
            end else begin
                prdata_d = ssp_pkg::RSVD_READ_VALUE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ranks_q <= {ssp_pkg::SEQ3_RANK_RST, ssp_pkg::SEQ2_RANK_RST,
                        ssp_pkg::SEQ1_RANK_RST, ssp_pkg::SEQ0_RANK_RST};
            prdata_q <= 32'h0000_0000;
        end else begin
            ranks_q <= ranks_d;
            prdata_q <= prdata_d;
        end
    end

    // ****************************************
    // Arbitration and sequencing
    // ****************************************
    ssp_pkg::ssp_state_t state_q, state_d;
    logic [1:0] id_q, id_d;
    logic start_q, start_d;
    logic grant_valid;
    logic [1:0] grant_id;

    ssp_arbiter u_arb (
        .ranks(ranks_q),
        .pending(pend_q),
        .grant_valid(grant_valid),
        .grant_id(grant_id)
    );

    always_comb begin
        state_d = state_q;
        id_d = id_q;
        start_d = 1'b0;
        pend_d = pend_q | trigger;
        case (state_q)
            ssp_pkg::SSP_IDLE: begin
                if (grant_valid) begin
                    state_d = ssp_pkg::SSP_RUN;
                    id_d = grant_id;
                    start_d = 1'b1;
                    // New trigger on the same sequencer is kept
                    pend_d[grant_id] = trigger[grant_id];
                end
            end
            ssp_pkg::SSP_RUN: begin
                if (seq_done) begin
                    state_d = ssp_pkg::SSP_IDLE;
                end
            end
            default: begin
                state_d = ssp_pkg::SSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ssp_pkg::SSP_IDLE;
            id_q <= 2'h0;
            start_q <= 1'b0;
            pend_q <= 4'h0;
        end else begin
            state_q <= state_d;
            id_q <= id_d;
            start_q <= start_d;
            pend_q <= pend_d;
        end
    end

    assign seq_start = start_q;
    assign seq_id = id_q;
    assign seq_busy = state_q == ssp_pkg::SSP_RUN;

    // ****************************************
    // Assertions
    // ****************************************
    AST_RESET_RANKS: assert property (@(posedge pclk)
        $rose(presetn) |-> pack_ranks(ranks_q) == 32'h0000_3210)
        else $error("Ranks not at reset values");

    AST_WRITE_TAKES: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_pri |=>
        pack_ranks(ranks_q) == ($past(pwdata) & 32'h0000_3333))
        else $error("Rank write not stored");

    AST_READ_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && hit_pri |-> (prdata & 32'hFFFF_CCCC) == 32'h0000_0000)
        else $error("Reserved bits read nonzero");

    AST_READ_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && hit_pri && !wr_en |-> prdata == pack_ranks(ranks_q))
        else $error("Read data differs from ranks");

    AST_START_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        seq_start |=> !seq_start && seq_busy)
        else $error("Start not a single pulse");

    AST_ONE_AT_A_TIME: assert property (@(posedge pclk) disable iff (!presetn)
        seq_busy && !seq_done |=> !seq_start)
        else $error("Start while busy");

    AST_MOST_URGENT: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ssp_pkg::SSP_IDLE && pend_q != 4'h0 && pend_q[1]
        && pend_q[0] && ranks_q.seq0_rank < ranks_q.seq1_rank
        |=> seq_start && seq_id != 2'h1)
        else $error("Less urgent sequencer started first");

    AST_IDLE_STARTS: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ssp_pkg::SSP_IDLE && pend_q != 4'h0 |=> seq_start)
        else $error("Pending sequencer not started");

endmodule : ssp_sequencer_priority

// File: test_ssp_sequencer_priority.sv
`timescale 1ns/1ps
module test_ssp_sequencer_priority;

    // ****************************************
    // Signals
    // ****************************************
    localparam logic [11:0] PRI = ssp_pkg::SEQUENCER_PRIORITY_OFFS;
    localparam logic [11:0] PEND = ssp_pkg::PENDING_STATUS_OFFS;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] trigger = 4'h0;
    logic seq_done = 1'h0;
    logic seq_start;
    logic [1:0] seq_id;
    logic seq_busy;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int samples_checked = 0;

    always #5 pclk = ~pclk;

    ssp_sequencer_priority i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger(trigger), .seq_done(seq_done), .seq_start(seq_start),
        .seq_id(seq_id), .seq_busy(seq_busy)
    );

    // ****************************************
    // Compare tasks and closing
    // ****************************************
    task automatic fail(input string msg);
        num_errors++;
        $display("[ERR] %0t %s", $time, msg);
    endtask : fail

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail($sformatf("word %h expected %h", got, exp));
        end
    endtask : cmp_word

    task automatic cmp_id(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail($sformatf("sequence id %h expected %h", got, exp));
        end
    endtask : cmp_id

    task automatic cmp_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            fail($sformatf("flag %b expected %b", got, exp));
        end
    endtask : cmp_bit

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // ****************************************
    // Access tasks
    // ****************************************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        e = pslverr;
        q = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Fire all four triggers together, expect ids in order, low pair first
    task automatic order(input logic [7:0] ids);
        int n;
        @(posedge pclk);
        trigger <= 4'hF;
        @(posedge pclk);
        trigger <= 4'h0;
        for (int k = 0; k < 4; k++) begin
            n = 0;
            do begin
                @(posedge pclk);
                #1 n++;
            end while (seq_start !== 1'h1 && n < 20);
            cmp_bit(seq_start, 1'h1);
            cmp_id(seq_id, ids[2*k +: 2]);
            @(posedge pclk);
            #1 cmp_bit(seq_busy, 1'h1);
            @(posedge pclk);
            seq_done <= 1'h1;
            @(posedge pclk);
            seq_done <= 1'h0;
        end
    endtask : order

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, PRI, 32'h0000_0000, rd, er);
        cmp_word(rd, 32'h0000_3210);
        cmp_bit(er, 1'h0);
        order(8'hE4);
        apb(1'h1, PRI, 32'h0000_0123, rd, er);
        apb(1'h0, PRI, 32'h0000_0000, rd, er);
        cmp_word(rd, 32'h0000_0123);
        order(8'h1B);
        apb(1'h1, PRI, 32'h0000_1302, rd, er);
        apb(1'h0, PRI, 32'h0000_0000, rd, er);
        cmp_word(rd, 32'h0000_1302);
        order(8'h8D);
        apb(1'h1, 12'h0FC, 32'h0000_0000, rd, er);
        cmp_bit(er, 1'h1);
        apb(1'h0, 12'h0FC, 32'h0000_0000, rd, er);
        cmp_bit(er, 1'h1);
        cmp_word(rd, 32'h0000_0000);
        apb(1'h0, PRI, 32'h0000_0000, rd, er);
        cmp_word(rd, 32'h0000_1302);
        apb(1'h0, PEND, 32'h0000_0000, rd, er);
        cmp_bit(er, 1'h0);
        cmp_word(rd, 32'h0000_0000);
        wrap_up();
    end

    // Watchdog
    initial begin
        repeat (3000) @(posedge pclk);
        fail("run did not finish in time");
        wrap_up();
    end

endmodule : test_ssp_sequencer_priority
